// ===== rtl/smcfg_slave.v
`timescale 1ns/1ps
// Operation
// - Mode digit 0 off, 1 auto full, 2 alternating
// - Valid command acked with operation, power digits
// - Invalid mode digit answered with failure letter
// - Modbus RTU or ASCII framing selectable
// - Analog outputs disabled under Modbus
// - Modbus selection presets 19200 baud even parity
// - Line 19200/9600/4800, 8E1 or 8N1
// - Slave address native address clamped 1..247
// - Measurements in input registers, no pairs
// - Every value one 16-bit register
// - Support functions 03, 04, 06, 10
// - Read exception status always returns zero
// - Slave ID answers own address; broadcast is taken but not answered
// - Register 0 altitude, range -100 to 5000
// - Register 1 is power plus 256 times operation
// - Operating mode byte decodes 0 to 4
// - Power byte 0 full, 1 alternating
// - Implausible writes rejected with exception
// - Writing 0x3247 to register 2 resets device
// - Register 2 always reads zero
// - Bad measurement reads 0xFFFF or 32767
`include "smcfg_regs.vh"

module smcfg_slave (
   input  wire        clk,            // System clock, 125 MHz
   input  wire        resetn,         // Async reset, active low
   // Configuration
   input  wire [7:0]  native_addr,    // Native protocol address
   input  wire [1:0]  proto_sel,      // Native, RTU or ASCII
   input  wire        proto_load,     // Pulse: apply proto_sel
   input  wire [1:0]  baud_sel_in,    // Requested baud rate
   input  wire        parity_en_in,   // Requested even parity
   input  wire        line_load,      // Pulse: apply line settings
   input  wire        ext_ctrl,       // External heater control line
   // Serial heater-mode command
   input  wire        cmd_valid,      // Pulse: mode digit present
   input  wire [7:0]  cmd_digit,      // ASCII mode digit
   output reg         rsp_valid,      // Pulse: reply ready
   output reg         rsp_ok,         // Reply is acknowledge form
   output reg  [7:0]  rsp_op_char,    // Operation digit or 'f'
   output reg  [7:0]  rsp_pwr_char,   // Power digit
   // Decoded Modbus request
   input  wire        req_valid,      // Pulse: request present
   input  wire [7:0]  req_slave,      // Addressed slave
   input  wire [7:0]  req_func,       // Function code
   input  wire [15:0] req_reg,        // Register address
   input  wire [15:0] req_data,       // Write data
   // Measurement input registers
   output wire [15:0] meas_index,     // Input register being read
   input  wire [15:0] meas_value,     // Scaled measurement
   input  wire        meas_ok,        // Measurement is valid
   input  wire        meas_signed,    // Measurement is signed
   // Modbus answer
   output reg         ans_valid,      // Pulse: answer ready
   output reg  [7:0]  ans_func,       // Echoed function code
   output reg  [7:0]  ans_exc,        // Exception code, 0 none
   output reg  [15:0] ans_data,       // Answer word
   // State outputs
   output reg  [7:0]  modbus_addr,    // Effective slave address
   output reg  [1:0]  proto,          // Active protocol
   output reg  [1:0]  baud_sel,       // Active baud rate
   output reg         parity_en,      // Even parity on
   output wire        analog_en,      // Analog outputs allowed
   output reg  [15:0] site_altitude,  // Altitude, metres
   output reg  [15:0] heater_config,  // Shared heater configuration
   output reg         heater_on,      // Heater enable
   output reg         heater_alt,     // Alternate elements
   output reg         heater_test,    // Maintenance test mode
   output reg         station_restart // Pulse: full device reset
);

   // ==================================================================
   // Decode helpers
   // Operating byte plausible
   function op_ok;
      input [7:0] op;
      begin
         op_ok = (op <= `SMCFG_OP_OFF_LO);
      end
   endfunction

   // Power byte plausible
   function pwr_ok;
      input [7:0] p;
      begin
         pwr_ok = (p <= `SMCFG_PWR_ALT);
      end
   endfunction

   // Signed altitude within limits
   function alt_ok;
      input [15:0] a;
      begin
         alt_ok = ($signed(a) >= $signed(`SMCFG_ALT_MIN)) &&
                  ($signed(a) <= $signed(`SMCFG_ALT_MAX));
      end
   endfunction

   // ==================================================================
   // Modbus request decode
   wire is_modbus  = (proto != `SMCFG_PROTO_NATIVE);
   wire own_addr   = (req_slave == modbus_addr);
   wire bcast      = (req_slave == `SMCFG_ADDR_BCAST);
   wire is_sid     = (req_func == `SMCFG_FC_SLAVE_ID);
   wire take_req   = req_valid && is_modbus &&
                     (own_addr || (bcast && is_sid));
   wire is_write   = (req_func == `SMCFG_FC_WR_SINGLE) ||
                     (req_func == `SMCFG_FC_WR_MULTI);
   wire hold_hit   = (req_reg <= `SMCFG_REG_RESTART);

   assign meas_index = req_reg;
   assign analog_en  = !is_modbus;

   // Plausibility of a holding write
   reg wr_ok;
   always @* begin
      case (req_reg)
         `SMCFG_REG_ALT:     wr_ok = alt_ok(req_data);
         `SMCFG_REG_HEAT:    wr_ok = op_ok(req_data[15:8]) &&
                                     pwr_ok(req_data[7:0]);
         `SMCFG_REG_RESTART: wr_ok = (req_data == `SMCFG_RESTART_MAGIC);
         default:            wr_ok = 1'b0;
      endcase
   end

   // Answer word and exception for the request
   reg [7:0]  next_exc;
   reg [15:0] next_data;
   always @* begin
      next_exc  = `SMCFG_EX_NONE;
      next_data = 16'h0000;
      case (req_func)
         `SMCFG_FC_RD_HOLD: begin
            if (!hold_hit)
               next_exc = `SMCFG_EX_ADDR;
            else if (req_reg == `SMCFG_REG_ALT)
               next_data = site_altitude;
            else if (req_reg == `SMCFG_REG_HEAT)
               next_data = heater_config;
            else
               next_data = 16'h0000;
         end
         `SMCFG_FC_RD_INPUT: begin
            if (req_reg >= `SMCFG_INPUT_REGS)
               next_exc = `SMCFG_EX_ADDR;
            else if (!meas_ok)
               next_data = meas_signed ? `SMCFG_ERR_SIGNED
                                       : `SMCFG_ERR_UNSIGNED;
            else
               next_data = meas_value;
         end
         `SMCFG_FC_WR_SINGLE, `SMCFG_FC_WR_MULTI: begin
            if (!hold_hit)
               next_exc = `SMCFG_EX_ADDR;
            else if (!wr_ok)
               next_exc = `SMCFG_EX_VALUE;
            else
               next_data = req_data;
         end
         `SMCFG_FC_RD_EXC:  next_data = 16'h0000;
         `SMCFG_FC_SLAVE_ID: next_data = {8'h00, modbus_addr};
         default:           next_exc = `SMCFG_EX_FUNC;
      endcase
   end

   wire do_write = take_req && is_write && hold_hit && wr_ok;

   // ==================================================================
   // Serial command decode
   wire cmd_good = (cmd_digit == `SMCFG_DIG_OFF) ||
                   (cmd_digit == `SMCFG_DIG_FULL) ||
                   (cmd_digit == `SMCFG_DIG_ALT);
   reg [15:0] cmd_heat;
   always @* begin
      case (cmd_digit)
         `SMCFG_DIG_FULL: cmd_heat = {`SMCFG_OP_AUTO, `SMCFG_PWR_FULL};
         `SMCFG_DIG_ALT:  cmd_heat = {`SMCFG_OP_AUTO, `SMCFG_PWR_ALT};
         default:         cmd_heat = {`SMCFG_OP_OFF, `SMCFG_PWR_FULL};
      endcase
   end

   // ==================================================================
   // Configuration state and answers
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         site_altitude   <= `SMCFG_ALT_RESET;
         heater_config   <= `SMCFG_HEAT_RESET;
         station_restart <= 1'b0;
         ans_valid       <= 1'b0;
         ans_func        <= 8'h00;
         ans_exc         <= `SMCFG_EX_NONE;
         ans_data        <= 16'h0000;
         rsp_valid       <= 1'b0;
         rsp_ok          <= 1'b0;
         rsp_op_char     <= 8'h00;
         rsp_pwr_char    <= 8'h00;
         proto           <= `SMCFG_PROTO_NATIVE;
         baud_sel        <= `SMCFG_BAUD_19200;
         parity_en       <= 1'b1;
         modbus_addr     <= `SMCFG_ADDR_MIN;
      end else begin
         station_restart <= 1'b0;
         // Slave address follows the native address
         if (native_addr > `SMCFG_ADDR_MAX)
            modbus_addr <= `SMCFG_ADDR_MAX;
         else if (native_addr == `SMCFG_ADDR_BCAST)
            modbus_addr <= `SMCFG_ADDR_MIN;
         else
            modbus_addr <= native_addr;
         // Protocol and line settings
         if (proto_load) begin
            proto <= proto_sel;
            if (proto_sel != `SMCFG_PROTO_NATIVE) begin
               baud_sel  <= `SMCFG_BAUD_19200;
               parity_en <= 1'b1;
            end
         end else if (line_load) begin
            baud_sel  <= baud_sel_in;
            parity_en <= parity_en_in;
         end
         // Modbus answer; broadcasts get none
         ans_valid <= take_req && own_addr;
         if (take_req) begin
            ans_func <= req_func;
            ans_exc  <= next_exc;
            ans_data <= next_data;
         end
         if (do_write) begin
            if (req_reg == `SMCFG_REG_ALT)
               site_altitude <= req_data;
            else if (req_reg == `SMCFG_REG_HEAT)
               heater_config <= req_data;
            else
               station_restart <= 1'b1;
         end
         // Serial heater command, Modbus write takes priority
         rsp_valid <= cmd_valid;
         if (cmd_valid) begin
            rsp_ok <= cmd_good;
            if (cmd_good) begin
               if (!(do_write && req_reg == `SMCFG_REG_HEAT))
                  heater_config <= cmd_heat;
               rsp_op_char  <= `SMCFG_ASCII_ZERO + cmd_heat[15:8];
               rsp_pwr_char <= `SMCFG_ASCII_ZERO + cmd_heat[7:0];
            end else begin
               rsp_op_char  <= `SMCFG_CHR_FAIL;
               rsp_pwr_char <= 8'h00;
            end
         end
      end
   end

   // ==================================================================
   // Heater drive from the shared configuration
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         heater_on   <= 1'b0;
         heater_alt  <= 1'b0;
         heater_test <= 1'b0;
      end else begin
         heater_alt  <= (heater_config[7:0] == `SMCFG_PWR_ALT);
         heater_test <= (heater_config[15:8] == `SMCFG_OP_TEST);
         case (heater_config[15:8])
            `SMCFG_OP_AUTO:   heater_on <= 1'b1;
            `SMCFG_OP_TEST:   heater_on <= 1'b1;
            `SMCFG_OP_OFF_HI: heater_on <= !ext_ctrl;
            `SMCFG_OP_OFF_LO: heater_on <= ext_ctrl;
            default:          heater_on <= 1'b0;
         endcase
      end
   end

endmodule // smcfg_slave

// ===== shared/smcfg_regs.vh
`ifndef SMCFG_REGS_VH
`define SMCFG_REGS_VH
// =====================================================================
// Holding register map (register addresses)
`define SMCFG_REG_ALT        16'h0000
`define SMCFG_REG_HEAT       16'h0001
`define SMCFG_REG_RESTART    16'h0002
`define SMCFG_RESTART_MAGIC  16'h3247
// Altitude limits, metres, two's complement
`define SMCFG_ALT_MIN        16'hFF9C
`define SMCFG_ALT_MAX        16'h1388
`define SMCFG_ALT_RESET      16'h0000
// Heater configuration, operating mode in high byte
`define SMCFG_OP_OFF         8'h00
`define SMCFG_OP_AUTO        8'h01
`define SMCFG_OP_TEST        8'h02
`define SMCFG_OP_OFF_HI      8'h03
`define SMCFG_OP_OFF_LO      8'h04
`define SMCFG_PWR_FULL       8'h00
`define SMCFG_PWR_ALT        8'h01
`define SMCFG_HEAT_RESET     16'h0100
// Function codes
`define SMCFG_FC_RD_HOLD     8'h03
`define SMCFG_FC_RD_INPUT    8'h04
`define SMCFG_FC_WR_SINGLE   8'h06
`define SMCFG_FC_RD_EXC      8'h07
`define SMCFG_FC_WR_MULTI    8'h10
`define SMCFG_FC_SLAVE_ID    8'h11
// Exception codes
`define SMCFG_EX_NONE        8'h00
`define SMCFG_EX_FUNC        8'h01
`define SMCFG_EX_ADDR        8'h02
`define SMCFG_EX_VALUE       8'h03
// Addressing
`define SMCFG_ADDR_BCAST     8'h00
`define SMCFG_ADDR_MAX       8'hF7
`define SMCFG_ADDR_MIN       8'h01
// Input register map size and error markers
`define SMCFG_INPUT_REGS     16'h007D
`define SMCFG_ERR_UNSIGNED   16'hFFFF
`define SMCFG_ERR_SIGNED     16'h7FFF
// Serial command mode digits and reply characters
`define SMCFG_DIG_OFF        8'h30
`define SMCFG_DIG_FULL       8'h31
`define SMCFG_DIG_ALT        8'h32
`define SMCFG_ASCII_ZERO     8'h30
`define SMCFG_CHR_FAIL       8'h66
// Line settings
`define SMCFG_BAUD_19200     2'b00
`define SMCFG_BAUD_9600      2'b01
`define SMCFG_BAUD_4800      2'b10
`define SMCFG_PROTO_NATIVE   2'b00
`define SMCFG_PROTO_RTU      2'b01
`define SMCFG_PROTO_ASCII    2'b10
`endif

// ===== verif/smcfg_master_model.sv
`timescale 1ns/1ps
// =====================================================================
// Master side: Modbus poller and serial command driver
module smcfg_master_model (
   input  wire        clk,       // System clock
   output reg         req_valid, // Request strobe
   output reg  [7:0]  req_slave, // Addressed slave
   output reg  [7:0]  req_func,  // Function code
   output reg  [15:0] req_reg,   // Register address
   output reg  [15:0] req_data,  // Write data
   output reg         cmd_valid, // Command strobe
   output reg  [7:0]  cmd_digit  // Mode digit
);
   // Idle bus after power-up
   initial begin
      {req_valid, req_slave, req_func, req_reg, req_data} = 'h0;
      {cmd_valid, cmd_digit} = 'h0;
   end
   // One request; stale fields scrambled once released
   task mb(input [7:0] s, input [7:0] f, input [15:0] r,
           input [15:0] d);
      begin
         @(negedge clk);
         {req_slave, req_func, req_reg, req_data} = {s, f, r, d};
         req_valid = 1'b1;
         @(negedge clk);
         req_valid = 1'b0;
         {req_slave, req_func, req_reg, req_data} = ~{s, f, r, d};
      end
   endtask
   // One heater mode digit
   task sdi(input [7:0] c);
      begin
         @(negedge clk);
         cmd_valid = 1'b1;
         cmd_digit = c;
         @(negedge clk);
         cmd_valid = 1'b0;
         cmd_digit = ~c;
      end
   endtask
endmodule // smcfg_master_model

// ===== verif/smcfg_slave_asserts.sv
`timescale 1ns/1ps
// =====================================================================
// Port checks of the configuration slave
module smcfg_slave_asserts (
   input wire        clk,            // System clock
   input wire        resetn,         // Reset, active low
   input wire [7:0]  native_addr,    // Native address
   input wire [1:0]  proto,          // Active protocol
   input wire        req_valid,      // Request strobe
   input wire [7:0]  req_slave,      // Addressed slave
   input wire [7:0]  req_func,       // Function code
   input wire [15:0] req_reg,        // Register address
   input wire [15:0] req_data,       // Write data
   input wire        cmd_valid,      // Command strobe
   input wire [7:0]  cmd_digit,      // Mode digit
   input wire        rsp_valid,      // Reply strobe
   input wire        rsp_ok,         // Reply form
   input wire        ans_valid,      // Answer strobe
   input wire [7:0]  ans_exc,        // Exception code
   input wire [15:0] ans_data,       // Answer word
   input wire        analog_en,      // Analog outputs allowed
   input wire        station_restart,// Restart pulse
   input wire [7:0]  modbus_addr     // Slave address
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Request accepted by this slave
   sequence s_take;
      req_valid && proto != 2'b00 && req_slave == modbus_addr;
   endsequence
   // Magic restart write
   sequence s_magic;
      s_take ##0 req_func == 8'h06 && req_reg == 16'h0002
         && req_data == 16'h3247;
   endsequence
   a_ans_next_cycle: assert property (
      s_take |=> ans_valid)
      else $error("answer missing after request");
   a_bcast_silent: assert property (
      req_valid && req_slave == 8'h00 |=> !ans_valid)
      else $error("answer to broadcast");
   a_restart_pulse: assert property (
      s_magic |=> station_restart ##1 !station_restart)
      else $error("restart pulse wrong");
   a_restart_cause: assert property (
      station_restart |-> $past(req_valid && req_data == 16'h3247))
      else $error("restart without magic write");
   a_reg2_zero: assert property (
      s_take ##0 req_func == 8'h03 && req_reg == 16'h0002
      |=> ans_data == 16'h0000 && ans_exc == 8'h00)
      else $error("restart register read not zero");
   a_exc_stat_zero: assert property (
      s_take ##0 req_func == 8'h07 |=> ans_data == 16'h0000)
      else $error("exception status not zero");
   a_alt_reject: assert property (
      s_take ##0 req_func == 8'h06 && req_reg == 16'h0000 &&
      ($signed(req_data) > 5000 || $signed(req_data) < -100)
      |=> ans_exc == 8'h03)
      else $error("bad altitude accepted");
   a_analog_off: assert property (
      proto != 2'b00 |-> !analog_en)
      else $error("analog enabled under Modbus");
   a_addr_clamp: assert property (
      native_addr > 8'hF7 |=> modbus_addr == 8'hF7)
      else $error("address not clamped");
   a_serial_reply: assert property (
      cmd_valid |=> rsp_valid &&
      rsp_ok == ($past(cmd_digit) inside {8'h30, 8'h31, 8'h32}))
      else $error("serial reply wrong");
endmodule // smcfg_slave_asserts

bind smcfg_slave smcfg_slave_asserts u_chk (.clk, .resetn, .native_addr,
   .proto, .req_valid, .req_slave, .req_func, .req_reg, .req_data, .cmd_valid,
   .cmd_digit, .rsp_valid, .rsp_ok, .ans_valid, .ans_exc, .ans_data,
   .analog_en, .station_restart, .modbus_addr);

// ===== verif/smcfg_slave_tb_top.sv
`timescale 1ns/1ps
// =====================================================================
// Testbench of the configuration slave
module smcfg_slave_tb_top;
   logic        clk = 1'b0;
   logic        resetn, proto_load, line_load, ext_ctrl, parity_en_in;
   logic        meas_ok, meas_signed, req_valid, cmd_valid, rsp_valid;
   logic        rsp_ok, ans_valid, parity_en, analog_en, heater_on;
   logic        heater_alt, heater_test, station_restart;
   logic [1:0]  proto_sel, baud_sel_in, proto, baud_sel;
   logic [7:0]  native_addr, req_slave, req_func, cmd_digit, rsp_op_char;
   logic [7:0]  rsp_pwr_char, ans_func, ans_exc, modbus_addr;
   logic [15:0] meas_value, meas_index, req_reg, req_data, ans_data;
   logic [15:0] site_altitude, heater_config;
   int          n_fail = 0;
   int          compares = 0;
   int          i;
   // 125 MHz clock
   always #4 clk = ~clk;
   smcfg_slave dut (.clk, .resetn, .native_addr, .proto_sel, .proto_load,
      .baud_sel_in, .parity_en_in, .line_load, .ext_ctrl, .cmd_valid,
      .cmd_digit, .rsp_valid, .rsp_ok, .rsp_op_char, .rsp_pwr_char,
      .req_valid, .req_slave, .req_func, .req_reg, .req_data, .meas_index,
      .meas_value, .meas_ok, .meas_signed, .ans_valid, .ans_func, .ans_exc,
      .ans_data, .modbus_addr, .proto, .baud_sel, .parity_en, .analog_en,
      .site_altitude, .heater_config, .heater_on, .heater_alt, .heater_test,
      .station_restart);
   smcfg_master_model m (.clk, .req_valid, .req_slave, .req_func, .req_reg,
      .req_data, .cmd_valid, .cmd_digit);
   // Result bookkeeping
   task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
      begin
         compares++;
         if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task tend(input string t);
      $display("test %s finished", t);
   endtask
   task test_done;
      begin
         $display("compares %0d n_fail %0d", compares, n_fail);
         if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   // Modbus request to slave 5, answer checked
   task mbx(input [7:0] f, input [15:0] r, d, input [7:0] x, input [15:0] q);
      begin
         m.mb(8'h05, f, r, d);
         cmp("ans_valid", 16'h1, ans_valid);
         cmp("ans_func", f, ans_func);
         cmp("ans_exc", x, ans_exc);
         if (x == 8'h00 && f != 8'h06 && f != 8'h10)
            cmp("ans_data", q, ans_data);
      end
   endtask
   // Serial mode digit; all ones means failure reply
   task ser(input [7:0] c, input [15:0] h);
      begin
         m.sdi(c);
         cmp("rsp_valid", 16'h1, rsp_valid);
         cmp("rsp_ok", h != 16'hFFFF, rsp_ok);
         cmp("rsp_chars", (h == 16'hFFFF) ? 16'h6600 : 16'h3030 + h,
             {rsp_op_char, rsp_pwr_char});
         if (h != 16'hFFFF)
            cmp("heater_config", h, heater_config);
      end
   endtask
   // Hang guard
   initial begin
      #200000;
      n_fail++;
      test_done;
   end
   // Main sequence
   initial begin
      {resetn, proto_load, line_load, ext_ctrl, meas_ok, meas_signed} = 6'h00;
      {parity_en_in, proto_sel, baud_sel_in} = 5'h01;
      native_addr = 8'hFA;
      meas_value = 16'h1234;
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      cmp("heater_config", 16'h0100, heater_config);
      line_load = 1'b1;
      @(negedge clk);
      line_load = 1'b0;
      cmp("modbus_addr", 16'h00F7, modbus_addr);
      cmp("line", 16'h0002, {baud_sel, parity_en});
      native_addr = 8'h05;
      for (i = 1; i < 3; i++) begin
         proto_sel = i[1:0];
         proto_load = 1'b1;
         @(negedge clk);
         proto_load = 1'b0;
         cmp("proto", i, proto);
         cmp("line", 16'h0001, {baud_sel, parity_en});
         cmp("analog_en", 16'h0, analog_en);
      end
      tend("protocol");
      mbx(8'h06, 16'h0000, 16'h1388, 8'h00, 16'h0);
      mbx(8'h06, 16'h0000, 16'h1389, 8'h03, 16'h0);
      mbx(8'h03, 16'h0000, 16'h0000, 8'h00, 16'h1388);
      mbx(8'h10, 16'h0000, 16'hFF9C, 8'h00, 16'h0);
      mbx(8'h06, 16'h0000, 16'hFF9B, 8'h03, 16'h0);
      mbx(8'h03, 16'h0000, 16'h0000, 8'h00, 16'hFF9C);
      cmp("site_altitude", 16'hFF9C, site_altitude);
      tend("altitude");
      mbx(8'h06, 16'h0001, 16'h0401, 8'h00, 16'h0);
      mbx(8'h06, 16'h0001, 16'h0501, 8'h03, 16'h0);
      mbx(8'h06, 16'h0001, 16'h0002, 8'h03, 16'h0);
      ext_ctrl = 1'b1;
      @(negedge clk);
      cmp("heater", 16'h0006, {heater_on, heater_alt, heater_test});
      ext_ctrl = 1'b0;
      @(negedge clk);
      cmp("heater_on", 16'h0, heater_on);
      mbx(8'h06, 16'h0001, 16'h0200, 8'h00, 16'h0);
      @(negedge clk);
      cmp("heater_test", 16'h1, heater_test);
      tend("heater register");
      ser(8'h30, 16'h0000);
      mbx(8'h03, 16'h0001, 16'h0000, 8'h00, 16'h0000);
      ser(8'h32, 16'h0101);
      ser(8'h31, 16'h0100);
      ser(8'h39, 16'hFFFF);
      mbx(8'h03, 16'h0001, 16'h0000, 8'h00, 16'h0100);
      tend("serial command");
      mbx(8'h07, 16'h0000, 16'h0000, 8'h00, 16'h0000);
      mbx(8'h11, 16'h0000, 16'h0000, 8'h00, 16'h0005);
      m.mb(8'h00, 8'h11, 16'h0000, 16'h0000);
      cmp("ans_valid", 16'h0, ans_valid);
      m.mb(8'h06, 8'h03, 16'h0000, 16'h0000);
      cmp("ans_valid", 16'h0, ans_valid);
      mbx(8'h05, 16'h0000, 16'h0000, 8'h01, 16'h0);
      mbx(8'h03, 16'h0003, 16'h0000, 8'h02, 16'h0);
      mbx(8'h06, 16'h0003, 16'h0005, 8'h02, 16'h0);
      mbx(8'h04, 16'h007D, 16'h0000, 8'h02, 16'h0);
      meas_ok = 1'b1;
      mbx(8'h04, 16'h007C, 16'h0000, 8'h00, 16'h1234);
      {meas_ok, meas_signed} = 2'b01;
      mbx(8'h04, 16'h000A, 16'h0000, 8'h00, 16'h7FFF);
      meas_signed = 1'b0;
      mbx(8'h04, 16'h000A, 16'h0000, 8'h00, 16'hFFFF);
      cmp("meas_index", 16'hFFF5, meas_index);
      tend("functions");
      mbx(8'h06, 16'h0002, 16'h0001, 8'h03, 16'h0);
      mbx(8'h03, 16'h0002, 16'h0000, 8'h00, 16'h0000);
      m.mb(8'h05, 8'h06, 16'h0002, 16'h3247);
      cmp("station_restart", 16'h1, station_restart);
      tend("restart");
      test_done;
   end
endmodule // smcfg_slave_tb_top
